// ### src/szpc_top.sv
// spindle zero point, safety speed check and axis number logic
`timescale 1ns/1ps
module szpc_top
  import szpc_pkg::*;
#(
  parameter int FILT_CYC = PROX_FILT_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  input  wire logic        prm_wr_en,
  input  wire logic [13:0] prm_wr_idx,
  input  wire logic [31:0] prm_wr_data,
  input  wire logic [13:0] prm_rd_idx,
  output logic      [31:0] prm_rd_data,
  input  wire logic        speed_obs_cmd,
  input  wire logic        zero_redetect_request,
  input  wire logic        z_phase_pulse,
  input  wire logic        prox_pin,
  input  wire logic [3:0]  axis_switch,
  output logic             prm_error,
  output logic      [7:0]  prm_error_code,
  output logic      [15:0] prm_error_number,
  output szpc_pkg::szpc_cfg_s zero_cfg,
  output logic             z_phase_passed,
  output logic             zero_redetect_complete,
  output logic      [4:0]  axis_number,
  output logic             axis_valid
);
  import szpc_pkg::*;

  // ---------------- parameter store ----------------
  logic [15:0] limit_r, end_speed_r, gear_a_r, gear_b_r;
  logic [15:0] func5_r, func7_r, zspec_r, orient_r, speed_r, tap_r;
  logic [31:0] cax_r;
  logic [15:0] limit_nxt, end_speed_nxt, gear_a_nxt, gear_b_nxt;
  logic [15:0] func5_nxt, func7_nxt, zspec_nxt, orient_nxt, speed_nxt;
  logic [15:0] tap_nxt;
  logic [31:0] cax_nxt, rd_nxt, rd_r;
  logic        changed_nxt, changed_r;
  logic [15:0] w16;
  logic [3:0]  din_w;
  logic        orient_ok;

  assign w16   = prm_wr_data[15:0];
  assign din_w = w16[POS_DIN_LO +: 4];
  // signed range check: |value| <= 35999
  assign orient_ok = w16[15] ? ((~w16 + 16'h0001) <= ORIENT_SHIFT_MAX)
                             : (w16 <= ORIENT_SHIFT_MAX);

  // out-of-range writes are dropped so the old setting stays in force
  always_comb begin
    limit_nxt     = limit_r;
    end_speed_nxt = end_speed_r;
    gear_a_nxt    = gear_a_r;
    gear_b_nxt    = gear_b_r;
    func5_nxt     = func5_r;
    func7_nxt     = func7_r;
    zspec_nxt     = zspec_r;
    orient_nxt    = orient_r;
    speed_nxt     = speed_r;
    tap_nxt       = tap_r;
    cax_nxt       = cax_r;
    changed_nxt   = 1'b0;
    if (prm_wr_en) begin
      changed_nxt = 1'b1;
      unique case (prm_wr_idx)
        IDX_SAFETY_LIMIT: if (w16 <= SAFETY_LIMIT_MAX) limit_nxt = w16;
        IDX_SAFETY_END:   end_speed_nxt = w16;
        IDX_GEAR_FIRST:   gear_a_nxt = w16;
        IDX_GEAR_SECOND:  gear_b_nxt = w16;
        IDX_FUNC_FIVE:    func5_nxt = w16;
        IDX_FUNC_SEVEN: begin
          if (din_w == DIN_NONE || din_w == DIN_DOOR ||
              din_w == DIN_PROX) begin
            func7_nxt = w16;
          end
        end
        IDX_ZERO_SPEC:    zspec_nxt = w16;
        IDX_ORIENT_SHIFT: if (orient_ok) orient_nxt = w16;
        IDX_SEARCH_SPEED: speed_nxt = w16;
        IDX_TAP_SHIFT:    if (w16 <= TAP_SHIFT_MAX) tap_nxt = w16;
        IDX_CAX_SHIFT: begin
          if (prm_wr_data <= CAX_SHIFT_MAX) cax_nxt = prm_wr_data;
        end
        default:          changed_nxt = 1'b0;
      endcase
    end
    unique case (prm_rd_idx)
      IDX_SAFETY_LIMIT: rd_nxt = {16'h0000, limit_r};
      IDX_SAFETY_END:   rd_nxt = {16'h0000, end_speed_r};
      IDX_GEAR_FIRST:   rd_nxt = {16'h0000, gear_a_r};
      IDX_GEAR_SECOND:  rd_nxt = {16'h0000, gear_b_r};
      IDX_FUNC_FIVE:    rd_nxt = {16'h0000, func5_r};
      IDX_FUNC_SEVEN:   rd_nxt = {16'h0000, func7_r};
      IDX_ZERO_SPEC:    rd_nxt = {16'h0000, zspec_r};
      IDX_ORIENT_SHIFT: rd_nxt = {{16{orient_r[15]}}, orient_r};
      IDX_SEARCH_SPEED: rd_nxt = {16'h0000, speed_r};
      IDX_TAP_SHIFT:    rd_nxt = {16'h0000, tap_r};
      IDX_CAX_SHIFT:    rd_nxt = cax_r;
      default:          rd_nxt = RST_PARAM32;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      limit_r     <= RST_PARAM16;
      end_speed_r <= RST_PARAM16;
      gear_a_r    <= RST_PARAM16;
      gear_b_r    <= RST_PARAM16;
      func5_r     <= RST_PARAM16;
      func7_r     <= RST_PARAM16;
      zspec_r     <= RST_PARAM16;
      orient_r    <= RST_PARAM16;
      speed_r     <= RST_PARAM16;
      tap_r       <= RST_PARAM16;
      cax_r       <= RST_PARAM32;
      rd_r        <= RST_PARAM32;
      changed_r   <= 1'b0;
    end else if (clk_en) begin
      limit_r     <= limit_nxt;
      end_speed_r <= end_speed_nxt;
      gear_a_r    <= gear_a_nxt;
      gear_b_r    <= gear_b_nxt;
      func5_r     <= func5_nxt;
      func7_r     <= func7_nxt;
      zspec_r     <= zspec_nxt;
      orient_r    <= orient_nxt;
      speed_r     <= speed_nxt;
      tap_r       <= tap_nxt;
      cax_r       <= cax_nxt;
      rd_r        <= rd_nxt;
      changed_r   <= changed_nxt;
    end
  end

  // ---------------- decoded zero return configuration ----------------
  szpc_cfg_s cfg_nxt, cfg_r;
  logic [1:0] zdir;

  assign zdir = zspec_r[POS_ZSEARCH_DIR] ? SZPC_DIR_REV : SZPC_DIR_FWD;

  always_comb begin
    cfg_nxt.prox_zero_en    = zspec_r[POS_PROX_EN];
    cfg_nxt.noninterp_gain  = zspec_r[POS_NONINTERP];
    cfg_nxt.spin_dir        = zspec_r[POS_SPIN_DIR +: 2];
    cfg_nxt.spin_decel_stop = zspec_r[POS_SPIN_DECEL];
    cfg_nxt.tap_reverse     = zspec_r[POS_TAP_POL];
    cfg_nxt.tap_dir         = zspec_r[POS_TAP_DIR +: 2];
    cfg_nxt.tap_decel_stop  = zspec_r[POS_TAP_DECEL];
    cfg_nxt.orient_dir      = zspec_r[POS_ORIENT_DIR +: 2];
    cfg_nxt.zsearch_reverse = zspec_r[POS_ZSEARCH_DIR];
    cfg_nxt.prox_rising     = func5_r[POS_EDGE_SEL];
    cfg_nxt.din_source      = func7_r[POS_DIN_LO +: 4];
    cfg_nxt.search_speed    = speed_r;
    // proximity detection lags the pulse edge, so spindle, tap and orient
    // moves all take the search direction to keep the stop point repeatable
    if (zspec_r[POS_PROX_EN]) begin
      cfg_nxt.spin_dir   = zdir;
      cfg_nxt.tap_dir    = zdir;
      cfg_nxt.orient_dir = zdir;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfg_r <= '0;
    end else if (clk_en) begin
      cfg_r <= cfg_nxt;
    end
  end

  // ---------------- safety speed relation check ----------------
  // floor(end*a / (360*b)) == limit, tested by cross multiplication
  szpc_chk_e   chk_r, chk_nxt;
  logic [47:0] num_r, lo_r, hi_r, num_nxt, lo_nxt, hi_nxt;
  logic        obs_d_r, boot_r, boot_nxt, trig;
  logic        err_r, err_nxt, unused_r, unused_nxt;
  logic        pend_r, pend_nxt;
  logic [47:0] den;
  logic [15:0] lim_eff;

  assign den     = 48'(gear_b_r) * 48'(DEG_PER_REV);
  assign lim_eff = (limit_r == 16'h0000) ? 16'h0001 : limit_r;
  assign trig    = boot_r | changed_r | (speed_obs_cmd & ~obs_d_r);

  always_comb begin
    chk_nxt    = chk_r;
    num_nxt    = num_r;
    lo_nxt     = lo_r;
    hi_nxt     = hi_r;
    err_nxt    = err_r;
    unused_nxt = unused_r;
    boot_nxt   = 1'b0;
    // a trigger landing mid-check is held, so the last change is judged
    pend_nxt   = pend_r | trig;
    unique case (chk_r)
      CHK_IDLE: if (trig | pend_r) begin
        chk_nxt    = CHK_EVAL;
        pend_nxt   = 1'b0;
        num_nxt    = 48'(end_speed_r) * 48'(gear_a_r);
        // a computed 0 counts as 1, so limit 1 covers num below den
        lo_nxt     = (limit_r == 16'h0001) ? 48'h0000_0000_0000
                                           : 48'(lim_eff) * den;
        hi_nxt     = 48'(lim_eff) * den + den;
        unused_nxt = (limit_r == 16'h0000) && (end_speed_r == 16'h0000);
      end
      CHK_EVAL: begin
        chk_nxt = CHK_DONE;
        err_nxt = ~unused_r &
                  ((den == 48'h0000_0000_0000) |
                   (limit_r == 16'h0000) |
                   (num_r < lo_r) | (num_r >= hi_r));
      end
      CHK_DONE: chk_nxt = CHK_IDLE;
      default:  chk_nxt = CHK_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      chk_r    <= CHK_IDLE;
      num_r    <= '0;
      lo_r     <= '0;
      hi_r     <= '0;
      err_r    <= 1'b0;
      unused_r <= 1'b0;
      obs_d_r  <= 1'b0;
      boot_r   <= 1'b1;
      pend_r   <= 1'b0;
    end else if (clk_en) begin
      chk_r    <= chk_nxt;
      num_r    <= num_nxt;
      lo_r     <= lo_nxt;
      hi_r     <= hi_nxt;
      err_r    <= err_nxt;
      unused_r <= unused_nxt;
      obs_d_r  <= speed_obs_cmd;
      boot_r   <= boot_nxt;
      pend_r   <= pend_nxt;
    end
  end

  // ---------------- zero point re-detection ----------------
  logic prox_edge, req_d_r, passed_r, done_r, passed_nxt, done_nxt;
  logic zero_event;

  szpc_prox_edge #(
    .FILT_CYC (FILT_CYC)
  ) u_prox (
    .core_clk   (core_clk),
    .rst        (rst),
    .clk_en     (clk_en),
    .prox_pin   (prox_pin),
    .rising_sel (cfg_r.prox_rising),
    .edge_pulse (prox_edge)
  );

  // proximity edges only count when the input is routed to the switch
  assign zero_event = cfg_r.prox_zero_en
                    ? (prox_edge & (cfg_r.din_source == DIN_PROX))
                    : z_phase_pulse;

  always_comb begin
    passed_nxt = passed_r;
    done_nxt   = done_r;
    if (zero_redetect_request & ~req_d_r) begin
      passed_nxt = 1'b0;
    end
    if (zero_event) begin
      passed_nxt = 1'b1; // set wins over the clear
    end
    if (zero_event & zero_redetect_request & (req_d_r | passed_nxt)) begin
      done_nxt = 1'b1;
    end
    if (~zero_redetect_request) begin
      done_nxt = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      req_d_r  <= 1'b0;
      passed_r <= 1'b0;
      done_r   <= 1'b0;
    end else if (clk_en) begin
      req_d_r  <= zero_redetect_request;
      passed_r <= passed_nxt;
      done_r   <= done_nxt;
    end
  end

  // ---------------- axis number capture ----------------
  logic [3:0] sw1_r, sw2_r, settle_r, settle_nxt;
  logic [4:0] axis_r, axis_nxt;
  logic       axis_ok_r, axis_ok_nxt;

  always_comb begin
    settle_nxt  = settle_r;
    axis_nxt    = axis_r;
    axis_ok_nxt = axis_ok_r;
    if (!axis_ok_r) begin
      settle_nxt = settle_r + 4'h1;
      if (settle_r == AXIS_SETTLE_CYC) begin
        axis_nxt    = {1'b0, sw2_r} + 5'h01;
        axis_ok_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sw1_r     <= 4'h0;
      sw2_r     <= 4'h0;
      settle_r  <= 4'h0;
      axis_r    <= 5'h00;
      axis_ok_r <= 1'b0;
    end else if (clk_en) begin
      sw1_r     <= axis_switch;
      sw2_r     <= sw1_r;
      settle_r  <= settle_nxt;
      axis_r    <= axis_nxt;
      axis_ok_r <= axis_ok_nxt;
    end
  end

  // ---------------- outputs ----------------
  assign prm_rd_data            = rd_r;
  assign prm_error              = err_r;
  assign prm_error_code         = err_r ? ERR_CODE_PARAM : ERR_CODE_NONE;
  assign prm_error_number       = err_r ? ERR_NUM_SAFETY : ERR_NUM_NONE;
  assign zero_cfg               = cfg_r;
  assign z_phase_passed         = passed_r;
  assign zero_redetect_complete = done_r;
  assign axis_number            = axis_r;
  assign axis_valid             = axis_ok_r;
endmodule // szpc_top

// ### src/szpc_pkg.sv
// spindle zero point configuration: shared constants and types
package szpc_pkg;
  // parameter numbers used as register indices on the parameter port
  localparam logic [13:0] IDX_SAFETY_LIMIT  = 14'h33b7;
  localparam logic [13:0] IDX_SAFETY_END    = 14'h33b6;
  localparam logic [13:0] IDX_GEAR_FIRST    = 14'h3301;
  localparam logic [13:0] IDX_GEAR_SECOND   = 14'h3305;
  localparam logic [13:0] IDX_FUNC_FIVE     = 14'h33a9;
  localparam logic [13:0] IDX_FUNC_SEVEN    = 14'h33ab;
  localparam logic [13:0] IDX_ZERO_SPEC     = 14'h0c22;
  localparam logic [13:0] IDX_ORIENT_SHIFT  = 14'h0c24;
  localparam logic [13:0] IDX_SEARCH_SPEED  = 14'h0c25;
  localparam logic [13:0] IDX_TAP_SHIFT     = 14'h0c27;
  localparam logic [13:0] IDX_CAX_SHIFT     = 14'h0c29;

  localparam logic [15:0] RST_PARAM16       = 16'h0000;
  localparam logic [31:0] RST_PARAM32       = 32'h0000_0000;

  // field positions
  localparam int POS_EDGE_SEL    = 5;
  localparam int POS_DIN_LO      = 12;
  localparam int POS_PROX_EN     = 15;
  localparam int POS_NONINTERP   = 14;
  localparam int POS_SPIN_DIR    = 9;
  localparam int POS_SPIN_DECEL  = 8;
  localparam int POS_TAP_POL     = 7;
  localparam int POS_TAP_DIR     = 5;
  localparam int POS_TAP_DECEL   = 4;
  localparam int POS_ORIENT_DIR  = 1;
  localparam int POS_ZSEARCH_DIR = 0;

  localparam logic [3:0]  DIN_NONE          = 4'h0;
  localparam logic [3:0]  DIN_DOOR          = 4'h1;
  localparam logic [3:0]  DIN_PROX          = 4'h4;

  // limits of the accepted settings, and degrees per revolution
  localparam logic [15:0] SAFETY_LIMIT_MAX  = 16'h7fff;
  localparam logic [15:0] ORIENT_SHIFT_MAX  = 16'h8c9f;
  localparam logic [15:0] TAP_SHIFT_MAX     = 16'h8c9f;
  localparam logic [31:0] CAX_SHIFT_MAX     = 32'h0005_7e3f;
  localparam logic [15:0] DEG_PER_REV       = 16'h0168;

  // parameter error report
  localparam logic [7:0]  ERR_CODE_PARAM    = 8'h37;
  localparam logic [7:0]  ERR_CODE_NONE     = 8'h00;
  localparam logic [15:0] ERR_NUM_SAFETY    = 16'h00ef;
  localparam logic [15:0] ERR_NUM_NONE      = 16'h0000;

  // cycles the axis switch is left to settle before it is caught, and the proximity filter length
  localparam logic [3:0]  AXIS_SETTLE_CYC   = 4'h4;
  localparam int          PROX_FILT_CYC     = 4;

  typedef enum logic [1:0] {
    SZPC_DIR_SHORT = 2'b00,
    SZPC_DIR_FWD   = 2'b01,
    SZPC_DIR_REV   = 2'b10
  } szpc_dir_e;

  typedef enum logic [2:0] {
    CHK_IDLE = 3'b001,
    CHK_EVAL = 3'b010,
    CHK_DONE = 3'b100
  } szpc_chk_e;

  typedef struct packed {
    logic        prox_zero_en;
    logic        noninterp_gain;
    logic [1:0]  spin_dir;
    logic        spin_decel_stop;
    logic        tap_reverse;
    logic [1:0]  tap_dir;
    logic        tap_decel_stop;
    logic [1:0]  orient_dir;
    logic        zsearch_reverse;
    logic        prox_rising;
    logic [3:0]  din_source;
    logic [15:0] search_speed;
  } szpc_cfg_s;
endpackage

// ### src/szpc_prox_edge.sv
// proximity switch input synchroniser, glitch filter and edge qualifier
`timescale 1ns/1ps
module szpc_prox_edge #(
  parameter int FILT_CYC = 4
) (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic clk_en,
  input  wire logic prox_pin,
  input  wire logic rising_sel,
  output logic      edge_pulse
);
  localparam int CW = $clog2(FILT_CYC + 1);
  localparam logic [CW-1:0] FILT_LAST = CW'(FILT_CYC - 1);

  logic          sync1_r, sync2_r, level_r, edge_r;
  logic [CW-1:0] cnt_r;
  logic          level_nxt, edge_nxt;
  logic [CW-1:0] cnt_nxt;
  logic [1:0]    prime_r, prime_nxt;

  // a new level must hold FILT_CYC cycles, so one transition gives at most one event
  always_comb begin
    level_nxt = level_r;
    edge_nxt  = 1'b0;
    cnt_nxt   = '0;
    prime_nxt = prime_r;
    if (prime_r != 2'b11) begin
      // adopt the settled pin level as idle so reset gives no false edge;
      // a pin change inside these first cycles is taken as the idle level
      prime_nxt = prime_r + 2'b01;
      level_nxt = sync2_r;
    end else if (sync2_r != level_r) begin
      cnt_nxt = cnt_r + 1'b1;
      if (cnt_r == FILT_LAST) begin
        level_nxt = sync2_r;
        cnt_nxt   = '0;
        edge_nxt  = rising_sel ? sync2_r : ~sync2_r;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      level_r <= 1'b0;
      edge_r  <= 1'b0;
      cnt_r   <= '0;
      prime_r <= 2'b00;
    end else if (clk_en) begin
      sync1_r <= prox_pin;
      sync2_r <= sync1_r;
      level_r <= level_nxt;
      edge_r  <= edge_nxt;
      cnt_r   <= cnt_nxt;
      prime_r <= prime_nxt;
    end
  end

  assign edge_pulse = edge_r;
endmodule // szpc_prox_edge

// ### bench/szpc_checker.sv
// concurrent checks on the ports of the spindle zero point block
`timescale 1ns/1ps
module szpc_checker
  import szpc_pkg::*;
#(
  parameter int FILT_CYC = 4
) (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        clk_en,
  input wire logic        prm_wr_en,
  input wire logic [13:0] prm_wr_idx,
  input wire logic [31:0] prm_wr_data,
  input wire logic [13:0] prm_rd_idx,
  input wire logic [31:0] prm_rd_data,
  input wire logic        speed_obs_cmd,
  input wire logic        zero_redetect_request,
  input wire logic        z_phase_pulse,
  input wire logic        prox_pin,
  input wire logic [3:0]  axis_switch,
  input wire logic        prm_error,
  input wire logic [7:0]  prm_error_code,
  input wire logic [15:0] prm_error_number,
  input wire szpc_pkg::szpc_cfg_s zero_cfg,
  input wire logic        z_phase_passed,
  input wire logic        zero_redetect_complete,
  input wire logic [4:0]  axis_number,
  input wire logic        axis_valid
);
  import szpc_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  chk_err_report: assert property (prm_error |->
    prm_error_code == ERR_CODE_PARAM && prm_error_number == ERR_NUM_SAFETY)
    else $error("error report fields wrong while error raised");
  chk_err_quiet: assert property (!prm_error |->
    prm_error_code == ERR_CODE_NONE && prm_error_number == ERR_NUM_NONE)
    else $error("error report fields set without error");
  chk_redet_clear: assert property (clk_en &&
    $rose(zero_redetect_request) && !z_phase_pulse |=> !z_phase_passed)
    else $error("passed flag kept after re-detection request");
  chk_cmpl_drop: assert property (clk_en &&
    !zero_redetect_request |=> !zero_redetect_complete)
    else $error("complete held without request");
  chk_cmpl_set: assert property (clk_en && zero_redetect_request &&
    z_phase_pulse |=> zero_redetect_complete && z_phase_passed)
    else $error("complete not set after zero event");
  chk_axis_hold: assert property (axis_valid |=>
    axis_valid && $stable(axis_number))
    else $error("axis number changed after capture");
  chk_axis_map: assert property ($rose(axis_valid) |->
    axis_number == {1'b0, axis_switch} + 5'h01)
    else $error("axis number not switch plus one");
  chk_prox_dirs: assert property (zero_cfg.prox_zero_en |->
    zero_cfg.orient_dir == zero_cfg.spin_dir &&
    zero_cfg.tap_dir == zero_cfg.spin_dir &&
    zero_cfg.spin_dir == (zero_cfg.zsearch_reverse ? 2'b10 : 2'b01))
    else $error("directions not following Z search direction");
endmodule // szpc_checker

// ### bench/szpc_nc_model.sv
// controller-side model: parameter writes, reads, re-detection signals
`timescale 1ns/1ps
module szpc_nc_model
  import szpc_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic [31:0] prm_rd_data,
  output logic             prm_wr_en,
  output logic      [13:0] prm_wr_idx,
  output logic      [31:0] prm_wr_data,
  output logic      [13:0] prm_rd_idx,
  output logic             zero_redetect_request,
  output logic             z_phase_pulse
);
  initial begin
    prm_wr_en = 1'b0;
    prm_wr_idx = 14'h0000;
    prm_wr_data = 32'h0000_0000;
    prm_rd_idx = 14'h0000;
    zero_redetect_request = 1'b0;
    z_phase_pulse = 1'b0;
  end
  // each write waits out the check so its result can be seen
  task automatic wr(input logic [13:0] idx, input logic [31:0] d);
    @(posedge core_clk);
    #1;
    prm_wr_en = 1'b1;
    prm_wr_idx = idx;
    prm_wr_data = (idx == IDX_ZERO_SPEC) ? (d & 32'h0000_c7f7) : d;
    @(posedge core_clk);
    #1;
    prm_wr_en = 1'b0;
    // released word is inverted so a stale value cannot pass for data
    prm_wr_data = ~prm_wr_data;
    prm_wr_idx = ~prm_wr_idx;
    repeat (4) @(posedge core_clk);
    #1;
  endtask
  // writes on two consecutive edges: the second lands while a check runs
  task automatic wr_pair(input logic [13:0] idx, input logic [31:0] d0, d1);
    @(posedge core_clk);
    #1;
    prm_wr_en = 1'b1;
    prm_wr_idx = idx;
    prm_wr_data = d0;
    @(posedge core_clk);
    #1;
    prm_wr_data = d1;
    @(posedge core_clk);
    #1;
    prm_wr_en = 1'b0;
    prm_wr_data = ~prm_wr_data;
    prm_wr_idx = ~prm_wr_idx;
    repeat (6) @(posedge core_clk);
    #1;
  endtask
  task automatic rd(input logic [13:0] idx, output logic [31:0] d);
    @(posedge core_clk);
    #1;
    prm_rd_idx = idx;
    @(posedge core_clk);
    #1;
    d = prm_rd_data;
  endtask
  task automatic req(input logic v);
    @(posedge core_clk);
    #1;
    zero_redetect_request = v;
    @(posedge core_clk);
    #1;
  endtask
  task automatic zpulse();
    @(posedge core_clk);
    #1;
    z_phase_pulse = 1'b1;
    @(posedge core_clk);
    #1;
    z_phase_pulse = 1'b0;
  endtask
endmodule // szpc_nc_model

// ### bench/test_spindle_zero_point_config.sv
// self-checking bench for the spindle zero point block
`timescale 1ns/1ps
module test_spindle_zero_point_config;
  import szpc_pkg::*;
  localparam int FILT_CYC = 2;
  logic core_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, speed_obs_cmd = 1'b0;
  logic prm_wr_en, z_phase_pulse, zero_redetect_request, prox_pin = 1'b0;
  logic [13:0] prm_wr_idx, prm_rd_idx;
  logic [31:0] prm_wr_data, prm_rd_data, rdv;
  logic [3:0]  axis_switch = 4'ha;
  logic prm_error, z_phase_passed, zero_redetect_complete, axis_valid;
  logic [7:0]  prm_error_code;
  logic [15:0] prm_error_number, spec;
  logic [4:0]  axis_number;
  logic [1:0]  dd;
  szpc_cfg_s   zero_cfg, ec;
  int err_total = 0, checked = 0;
  logic [13:0] tix [7] = '{IDX_TAP_SHIFT, IDX_TAP_SHIFT, IDX_CAX_SHIFT,
    IDX_CAX_SHIFT, IDX_ORIENT_SHIFT, IDX_FUNC_SEVEN, IDX_FUNC_SEVEN};
  logic [31:0] twr [7] = '{32'h0000_8c9f, 32'h0000_8ca0, 32'h0005_7e3f,
    32'h0005_7e40, 32'h0000_ff9c, 32'h0000_4000, 32'h0000_2000};
  logic [31:0] trd [7] = '{32'h0000_8c9f, 32'h0000_8c9f, 32'h0005_7e3f,
    32'h0005_7e3f, 32'hffff_ff9c, 32'h0000_4000, 32'h0000_4000};

  always #20 core_clk = ~core_clk;

  szpc_top #(.FILT_CYC(FILT_CYC)) szpc_top_i (
    .core_clk(core_clk), .rst(rst), .clk_en(clk_en),
    .prm_wr_en(prm_wr_en), .prm_wr_idx(prm_wr_idx),
    .prm_wr_data(prm_wr_data), .prm_rd_idx(prm_rd_idx),
    .prm_rd_data(prm_rd_data), .speed_obs_cmd(speed_obs_cmd),
    .zero_redetect_request(zero_redetect_request),
    .z_phase_pulse(z_phase_pulse), .prox_pin(prox_pin),
    .axis_switch(axis_switch), .prm_error(prm_error),
    .prm_error_code(prm_error_code), .prm_error_number(prm_error_number),
    .zero_cfg(zero_cfg), .z_phase_passed(z_phase_passed),
    .zero_redetect_complete(zero_redetect_complete),
    .axis_number(axis_number), .axis_valid(axis_valid));

  szpc_nc_model szpc_nc_model_i (
    .core_clk(core_clk), .prm_rd_data(prm_rd_data),
    .prm_wr_en(prm_wr_en), .prm_wr_idx(prm_wr_idx),
    .prm_wr_data(prm_wr_data), .prm_rd_idx(prm_rd_idx),
    .zero_redetect_request(zero_redetect_request),
    .z_phase_pulse(z_phase_pulse));

  task automatic cmp(input string nm, input logic [63:0] got, exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chk_err(input logic e);
    cmp("error", prm_error, e);
    cmp("code", prm_error_code, e ? 8'h37 : 8'h00);
    cmp("number", prm_error_number, e ? 16'h00ef : 16'h0000);
  endtask
  task automatic wait_passed();
    for (int i = 0; i < 20 && z_phase_passed !== 1'b1; i++)
      @(posedge core_clk);
    #1;
  endtask
  task automatic final_report();
    if (err_total == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    #400000;
    err_total++;
    final_report();
  end

  initial begin
    repeat (5) @(posedge core_clk);
    #1 rst = 1'b0;
    repeat (10) @(posedge core_clk);
    #1;
    cmp("axis", {axis_valid, axis_number}, 6'h2b);
    chk_err(1'b0);
    axis_switch = 4'h3;
    szpc_nc_model_i.wr(IDX_GEAR_FIRST, 32'd2);
    szpc_nc_model_i.wr(IDX_GEAR_SECOND, 32'd1);
    szpc_nc_model_i.wr(IDX_SAFETY_END, 32'd3600);
    chk_err(1'b1);
    szpc_nc_model_i.wr(IDX_SAFETY_LIMIT, 32'd20);
    chk_err(1'b0);
    szpc_nc_model_i.wr(IDX_SAFETY_LIMIT, 32'd21);
    chk_err(1'b1);
    szpc_nc_model_i.wr(IDX_SAFETY_END, 32'd100);
    chk_err(1'b1);
    szpc_nc_model_i.wr(IDX_SAFETY_LIMIT, 32'd1);
    chk_err(1'b0);
    szpc_nc_model_i.wr(IDX_SAFETY_LIMIT, 32'h0000_8000);
    szpc_nc_model_i.rd(IDX_SAFETY_LIMIT, rdv);
    cmp("limit", rdv, 32'd1);
    @(posedge core_clk);
    #1 speed_obs_cmd = 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    chk_err(1'b0);
    szpc_nc_model_i.wr_pair(IDX_SAFETY_END, 32'd3600, 32'd100);
    chk_err(1'b0);
    for (int i = 0; i < 7; i++) begin
      szpc_nc_model_i.wr(tix[i], twr[i]);
      szpc_nc_model_i.rd(tix[i], rdv);
      cmp("readback", rdv, trd[i]);
    end
    szpc_nc_model_i.rd(14'h0000, rdv);
    cmp("unmapped", rdv, 32'h0000_0000);
    szpc_nc_model_i.wr(IDX_FUNC_FIVE, 32'h0000_0020);
    szpc_nc_model_i.wr(IDX_SEARCH_SPEED, 32'h0000_01f4);
    for (int k = 0; k < 5; k++) begin
      dd = (k < 3) ? k[1:0] : {k[0], ~k[0]};
      spec = {k >= 3, k[0], 3'b000, dd, k[1], k[0], dd, k[1], 1'b0, dd,
              k[0]};
      szpc_nc_model_i.wr(IDX_ZERO_SPEC, {16'h0000, spec});
      ec = '{spec[15], spec[14], spec[10:9], spec[8], spec[7], spec[6:5],
             spec[4], spec[2:1], spec[0], 1'b1, 4'h4, 16'h01f4};
      if (spec[15])
        {ec.spin_dir, ec.tap_dir, ec.orient_dir} = {3{spec[0] ? 2'b10
                                                              : 2'b01}};
      cmp("config", zero_cfg, ec);
    end
    szpc_nc_model_i.wr(IDX_ZERO_SPEC, 32'h0000_0000);
    szpc_nc_model_i.zpulse();
    cmp("passed", {z_phase_passed, zero_redetect_complete}, 2'b10);
    szpc_nc_model_i.req(1'b1);
    cmp("passed", z_phase_passed, 1'b0);
    szpc_nc_model_i.zpulse();
    cmp("done", {z_phase_passed, zero_redetect_complete}, 2'b11);
    szpc_nc_model_i.req(1'b0);
    cmp("done", zero_redetect_complete, 1'b0);
    szpc_nc_model_i.wr(IDX_ZERO_SPEC, 32'h0000_8000);
    szpc_nc_model_i.req(1'b1);
    prox_pin = 1'b1;
    wait_passed();
    cmp("prox rise", {z_phase_passed, zero_redetect_complete}, 2'b11);
    szpc_nc_model_i.req(1'b0);
    szpc_nc_model_i.req(1'b1);
    prox_pin = 1'b0;
    repeat (12) @(posedge core_clk);
    #1 prox_pin = 1'b1;
    @(posedge core_clk);
    #1 prox_pin = 1'b0;
    repeat (12) @(posedge core_clk);
    #1;
    cmp("prox fall", z_phase_passed, 1'b0);
    prox_pin = 1'b1;
    wait_passed();
    cmp("prox rise", z_phase_passed, 1'b1);
    szpc_nc_model_i.req(1'b0);
    szpc_nc_model_i.req(1'b1);
    szpc_nc_model_i.wr(IDX_FUNC_FIVE, 32'h0000_0000);
    cmp("passed", z_phase_passed, 1'b0);
    prox_pin = 1'b0;
    wait_passed();
    cmp("prox fall", z_phase_passed, 1'b1);
    cmp("axis", {axis_valid, axis_number}, 6'h2b);
    final_report();
  end
endmodule // test_spindle_zero_point_config

bind szpc_top szpc_checker #(.FILT_CYC(FILT_CYC)) szpc_checker_i (
  .core_clk(core_clk), .rst(rst), .clk_en(clk_en),
  .prm_wr_en(prm_wr_en), .prm_wr_idx(prm_wr_idx),
  .prm_wr_data(prm_wr_data), .prm_rd_idx(prm_rd_idx),
  .prm_rd_data(prm_rd_data), .speed_obs_cmd(speed_obs_cmd),
  .zero_redetect_request(zero_redetect_request),
  .z_phase_pulse(z_phase_pulse), .prox_pin(prox_pin),
  .axis_switch(axis_switch), .prm_error(prm_error),
  .prm_error_code(prm_error_code), .prm_error_number(prm_error_number),
  .zero_cfg(zero_cfg), .z_phase_passed(z_phase_passed),
  .zero_redetect_complete(zero_redetect_complete),
  .axis_number(axis_number), .axis_valid(axis_valid));
